// ### design/frdc_pkg.sv
package frdc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [15:0] ADDR_FAST_OV = 16'hFE01;
	localparam logic [15:0] ADDR_OPEN_LOOP = 16'hFE02;
	localparam logic [15:0] ADDR_IO_OV = 16'hFE03;
	localparam logic [15:0] ADDR_CORE_OV = 16'hFE04;
	localparam logic [15:0] ADDR_DEBOUNCE = 16'hFE05;

	localparam logic [7:0] MASK_ACTION = 8'hC0;
	localparam logic [7:0] MASK_SUPPLY = 8'h7F;
	localparam logic [7:0] MASK_DEBOUNCE = 8'hFF;
	localparam logic [7:0] RST_REG = 8'h00;

	// Field positions
	localparam int ACT_HI = 7;
	localparam int ACT_LO = 6;
	localparam int SUP_SAVE_BIT = 6;
	localparam int SUP_RETRY_HI = 5;
	localparam int SUP_RETRY_LO = 3;
	localparam int SUP_RELOAD_BIT = 2;
	localparam int SUP_DEB_BIT = 1;
	localparam int SUP_IGNORE_BIT = 0;
	localparam int DEB_LOK_RISE_LO = 6;
	localparam int DEB_LOK_FALL_LO = 4;
	localparam int DEB_PG_RISE_LO = 2;
	localparam int DEB_PG_FALL_LO = 0;

	typedef enum logic [1:0] {
		ACT_IGNORE = 2'h0,
		ACT_RESTART = 2'h1,
		ACT_WAIT_PON = 2'h2,
		ACT_DISABLE = 2'h3
	} frdc_action_t;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_PON_DLY = 3'b001,
		ST_RUN = 3'b010,
		ST_RETRY = 3'b011,
		ST_DISABLED = 3'b100,
		ST_LATCHED = 3'b101
	} frdc_state_t;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint CLK_KHZ = 50_000;
	localparam longint CLK_MHZ = 50;
	localparam longint RETRY_UNIT_MS = 588;
	localparam longint DEB_SHORT_NS = 2_560;
	localparam longint DEB_LONG_NS = 660_000;
	localparam longint STAT_DEB1_MS = 200;
	localparam longint STAT_DEB2_MS = 320;
	localparam longint STAT_DEB3_MS = 600;
	localparam longint PON_DLY1_MS = 50;
	localparam longint PON_DLY2_MS = 250;
	localparam longint PON_DLY3_MS = 1000;

	localparam longint RETRY_UNIT_CYC = RETRY_UNIT_MS * CLK_KHZ;
	localparam longint DEB_SHORT_CYC = (DEB_SHORT_NS * CLK_MHZ) / 1000;
	localparam longint DEB_LONG_CYC = (DEB_LONG_NS * CLK_MHZ) / 1000;
	localparam longint STAT_DEB1_CYC = STAT_DEB1_MS * CLK_KHZ;
	localparam longint STAT_DEB2_CYC = STAT_DEB2_MS * CLK_KHZ;
	localparam longint STAT_DEB3_CYC = STAT_DEB3_MS * CLK_KHZ;
	localparam longint PON_DLY1_CYC = PON_DLY1_MS * CLK_KHZ;
	localparam longint PON_DLY2_CYC = PON_DLY2_MS * CLK_KHZ;
	localparam longint PON_DLY3_CYC = PON_DLY3_MS * CLK_KHZ;

	localparam int DEB_W = 25;
	localparam int TMR_W = 28;
	localparam int NUM_DEB = 4;

	// Debouncer slots
	localparam int SLOT_LOK = 0;
	localparam int SLOT_PG = 1;
	localparam int SLOT_IO = 2;
	localparam int SLOT_CORE = 3;

	// Fault flag bit positions
	localparam int FLG_FAST_OV = 0;
	localparam int FLG_OPEN_LOOP = 1;
	localparam int FLG_IO_OV = 2;
	localparam int FLG_CORE_OV = 3;

endpackage

// ### design/frdc_debounce.sv
`timescale 1ns/1ns
module frdc_debounce
	import frdc_pkg::*;
#(
	parameter int W = DEB_W
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Level and intervals
	input wire logic level_i,
	input wire logic [W-1:0] rise_cyc_i,
	input wire logic [W-1:0] fall_cyc_i,
	// Filtered level
	output logic level_o
);

	logic level_r;
	logic [W-1:0] cnt_r;
	logic [W-1:0] limit;

	assign limit = level_r ? fall_cyc_i : rise_cyc_i;
	assign level_o = level_r;

	// Counter restarts on any bounce back to the held level
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			level_r <= 1'b0;
			cnt_r <= '0;
		end else if (level_i == level_r) begin
			cnt_r <= '0;
		end else if (cnt_r + W'(1) >= limit) begin
			level_r <= level_i;
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + W'(1);
		end
	end

endmodule

// ### design/frdc_top.sv
`timescale 1ns/1ns
module frdc_top
	import frdc_pkg::*;
#(
	parameter int RETRY_UNIT = int'(RETRY_UNIT_CYC),
	parameter int DEB_SHORT = int'(DEB_SHORT_CYC),
	parameter int DEB_LONG = int'(DEB_LONG_CYC),
	parameter int STAT_DEB1 = int'(STAT_DEB1_CYC),
	parameter int STAT_DEB2 = int'(STAT_DEB2_CYC),
	parameter int STAT_DEB3 = int'(STAT_DEB3_CYC),
	parameter int PON_DLY1 = int'(PON_DLY1_CYC),
	parameter int PON_DLY2 = int'(PON_DLY2_CYC),
	parameter int PON_DLY3 = int'(PON_DLY3_CYC)
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register port from the management interface
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Fault detectors
	input wire logic fast_ov_fault_i,
	input wire logic open_loop_fault_i,
	input wire logic io_ov_fault_i,
	input wire logic core_ov_fault_i,
	input wire logic flag_clear_i,
	// Power-on request and delay select from the power-on delay register
	input wire logic power_on_request_i,
	input wire logic [1:0] pon_delay_sel_i,
	// Raw status levels
	input wire logic line_ok_raw_i,
	input wire logic power_good_raw_i,
	// Power stage control
	output logic pwm_enable_o,
	output logic soft_start_o,
	// Nonvolatile memory requests
	output logic save_fault_id_o,
	output logic reload_config_o,
	// Status
	output logic line_ok_output_o,
	output logic power_good_output_o,
	output logic [3:0] fault_flags_o,
	output logic [2:0] state_o
);

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic [DEB_W-1:0] stat_deb(input logic [1:0] sel);
		case (sel)
			2'h0: stat_deb = '0;
			2'h1: stat_deb = DEB_W'(STAT_DEB1);
			2'h2: stat_deb = DEB_W'(STAT_DEB2);
			default: stat_deb = DEB_W'(STAT_DEB3);
		endcase
	endfunction

	function automatic logic [DEB_W-1:0] sup_deb(input logic fast);
		sup_deb = fast ? DEB_W'(DEB_SHORT) : DEB_W'(DEB_LONG);
	endfunction

	function automatic logic [TMR_W-1:0] retry_cyc(input logic [7:0] sup);
		retry_cyc = TMR_W'(sup[SUP_RETRY_HI:SUP_RETRY_LO]) * TMR_W'(RETRY_UNIT);
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] fast_overvoltage_action_r;
	logic [7:0] open_loop_action_r;
	logic [7:0] io_supply_overvoltage_action_r;
	logic [7:0] core_supply_overvoltage_action_r;
	logic [7:0] status_output_debounce_r;
	logic [7:0] rdata_r;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			fast_overvoltage_action_r <= RST_REG;
			open_loop_action_r <= RST_REG;
			io_supply_overvoltage_action_r <= RST_REG;
			core_supply_overvoltage_action_r <= RST_REG;
			status_output_debounce_r <= RST_REG;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_FAST_OV: fast_overvoltage_action_r <= reg_wdata_i & MASK_ACTION;
				ADDR_OPEN_LOOP: open_loop_action_r <= reg_wdata_i & MASK_ACTION;
				ADDR_IO_OV: io_supply_overvoltage_action_r <= reg_wdata_i & MASK_SUPPLY;
				ADDR_CORE_OV: core_supply_overvoltage_action_r <= reg_wdata_i & MASK_SUPPLY;
				ADDR_DEBOUNCE: status_output_debounce_r <= reg_wdata_i & MASK_DEBOUNCE;
				default: ;
			endcase
		end
	end

	// Read data registered one cycle after the strobe; unmapped reads zero
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_r <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_FAST_OV: rdata_r <= fast_overvoltage_action_r;
				ADDR_OPEN_LOOP: rdata_r <= open_loop_action_r;
				ADDR_IO_OV: rdata_r <= io_supply_overvoltage_action_r;
				ADDR_CORE_OV: rdata_r <= core_supply_overvoltage_action_r;
				ADDR_DEBOUNCE: rdata_r <= status_output_debounce_r;
				default: rdata_r <= 8'h00;
			endcase
		end
	end

	assign reg_rdata_o = rdata_r;

	// ----------------------------------------
	// Debouncers
	// ----------------------------------------
	logic [NUM_DEB-1:0] deb_in;
	logic [NUM_DEB-1:0] deb_out;
	logic [DEB_W-1:0] deb_rise [NUM_DEB];
	logic [DEB_W-1:0] deb_fall [NUM_DEB];

	assign deb_in[SLOT_LOK] = line_ok_raw_i;
	assign deb_in[SLOT_PG] = power_good_raw_i;
	assign deb_in[SLOT_IO] = io_ov_fault_i;
	assign deb_in[SLOT_CORE] = core_ov_fault_i;

	assign deb_rise[SLOT_LOK] = stat_deb(status_output_debounce_r[DEB_LOK_RISE_LO+:2]);
	assign deb_fall[SLOT_LOK] = stat_deb(status_output_debounce_r[DEB_LOK_FALL_LO+:2]);
	assign deb_rise[SLOT_PG] = stat_deb(status_output_debounce_r[DEB_PG_RISE_LO+:2]);
	assign deb_fall[SLOT_PG] = stat_deb(status_output_debounce_r[DEB_PG_FALL_LO+:2]);
	// Supply faults are filtered on assertion only; release is immediate
	assign deb_rise[SLOT_IO] = sup_deb(io_supply_overvoltage_action_r[SUP_DEB_BIT]);
	assign deb_fall[SLOT_IO] = '0;
	assign deb_rise[SLOT_CORE] = sup_deb(core_supply_overvoltage_action_r[SUP_DEB_BIT]);
	assign deb_fall[SLOT_CORE] = '0;

	generate
		for (genvar i = 0; i < NUM_DEB; i++) begin : g_deb
			frdc_debounce #(
				.W(DEB_W)
			) u_deb (
				.mclk_i(mclk_i),
				.rst_i(rst_i),
				.level_i(deb_in[i]),
				.rise_cyc_i(deb_rise[i]),
				.fall_cyc_i(deb_fall[i]),
				.level_o(deb_out[i])
			);
		end
	endgenerate

	assign line_ok_output_o = deb_out[SLOT_LOK];
	assign power_good_output_o = deb_out[SLOT_PG];

	// ----------------------------------------
	// Fault qualification and flags
	// ----------------------------------------
	frdc_action_t act_fov;
	frdc_action_t act_open;
	logic io_ov_q;
	logic core_ov_q;
	logic fov_q;
	logic open_q;
	logic [3:0] flags_r;
	logic [3:0] flags_set;

	assign act_fov = frdc_action_t'(fast_overvoltage_action_r[ACT_HI:ACT_LO]);
	assign act_open = frdc_action_t'(open_loop_action_r[ACT_HI:ACT_LO]);
	assign io_ov_q = deb_out[SLOT_IO] & ~io_supply_overvoltage_action_r[SUP_IGNORE_BIT];
	assign core_ov_q = deb_out[SLOT_CORE] & ~core_supply_overvoltage_action_r[SUP_IGNORE_BIT];
	// Ignore code masks the fault entirely, flag included
	assign fov_q = fast_ov_fault_i & (act_fov != ACT_IGNORE);
	assign open_q = open_loop_fault_i & (act_open != ACT_IGNORE);

	always_comb begin
		flags_set = 4'h0;
		flags_set[FLG_FAST_OV] = fov_q;
		flags_set[FLG_OPEN_LOOP] = open_q;
		flags_set[FLG_IO_OV] = io_ov_q;
		flags_set[FLG_CORE_OV] = core_ov_q;
	end

	// A fault present during the clear cycle keeps its flag
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			flags_r <= 4'h0;
		end else begin
			flags_r <= (flags_r & {4{~flag_clear_i}}) | flags_set;
		end
	end

	assign fault_flags_o = flags_r;

	// ----------------------------------------
	// Response sequencer
	// ----------------------------------------
	frdc_state_t state_r;
	frdc_state_t state_nxt;
	logic [TMR_W-1:0] tmr_r;
	logic [TMR_W-1:0] tmr_nxt;
	logic pon_prev_r;
	logic pon_rise;
	logic want_wait;
	logic want_dis;
	logic want_sup;
	logic want_rst;
	logic hold_dis;
	logic save_nxt;
	logic reload_nxt;
	logic [TMR_W-1:0] pon_cyc;

	assign pon_rise = power_on_request_i & ~pon_prev_r;
	assign want_wait = (fov_q && act_fov == ACT_WAIT_PON) || (open_q && act_open == ACT_WAIT_PON);
	assign want_dis = (fov_q && act_fov == ACT_DISABLE) || (open_q && act_open == ACT_DISABLE);
	assign want_rst = (fov_q && act_fov == ACT_RESTART) || (open_q && act_open == ACT_RESTART);
	assign want_sup = io_ov_q | core_ov_q;
	assign hold_dis = (flags_r[FLG_FAST_OV] && act_fov == ACT_DISABLE)
		|| (flags_r[FLG_OPEN_LOOP] && act_open == ACT_DISABLE);

	always_comb begin
		case (pon_delay_sel_i)
			2'h0: pon_cyc = '0;
			2'h1: pon_cyc = TMR_W'(PON_DLY1);
			2'h2: pon_cyc = TMR_W'(PON_DLY2);
			default: pon_cyc = TMR_W'(PON_DLY3);
		endcase
	end

	// Priority: latch-off beats disable beats supply retry beats quick restart
	always_comb begin
		state_nxt = state_r;
		tmr_nxt = (tmr_r != '0) ? tmr_r - TMR_W'(1) : tmr_r;
		save_nxt = 1'b0;
		reload_nxt = 1'b0;
		case (state_r)
			ST_OFF: begin
				if (power_on_request_i) begin
					state_nxt = ST_PON_DLY;
					tmr_nxt = pon_cyc;
				end
			end
			ST_PON_DLY: begin
				if (tmr_r == '0) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (want_wait) begin
					state_nxt = ST_LATCHED;
				end else if (want_dis) begin
					state_nxt = ST_DISABLED;
				end else if (want_sup) begin
					state_nxt = ST_RETRY;
					if (io_ov_q) begin
						tmr_nxt = retry_cyc(io_supply_overvoltage_action_r);
						save_nxt = io_supply_overvoltage_action_r[SUP_SAVE_BIT];
						reload_nxt = io_supply_overvoltage_action_r[SUP_RELOAD_BIT];
					end else begin
						tmr_nxt = retry_cyc(core_supply_overvoltage_action_r);
						save_nxt = core_supply_overvoltage_action_r[SUP_SAVE_BIT];
						reload_nxt = core_supply_overvoltage_action_r[SUP_RELOAD_BIT];
					end
				end else if (want_rst) begin
					state_nxt = ST_RETRY;
					tmr_nxt = '0;
				end
			end
			ST_RETRY: begin
				if (tmr_r == '0 && !want_sup) begin
					state_nxt = ST_RUN;
				end
			end
			ST_DISABLED: begin
				if (!hold_dis) begin
					state_nxt = ST_RUN;
				end
			end
			ST_LATCHED: begin
				if (pon_rise) begin
					state_nxt = ST_PON_DLY;
					tmr_nxt = pon_cyc;
				end
			end
			default: begin
				state_nxt = ST_OFF;
			end
		endcase
		// Dropping the request turns the stage off from any state except latched
		if (!power_on_request_i && state_r != ST_LATCHED) begin
			state_nxt = ST_OFF;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_OFF;
			tmr_r <= '0;
			pon_prev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
			pon_prev_r <= power_on_request_i;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic pwm_en_r;
	logic ss_r;
	logic save_r;
	logic reload_r;

	// Ignore code never leaves run, so switching continues
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_en_r <= 1'b0;
			ss_r <= 1'b0;
		end else begin
			pwm_en_r <= (state_nxt == ST_RUN);
			ss_r <= (state_nxt == ST_RUN) && (state_r != ST_RUN);
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			save_r <= 1'b0;
			reload_r <= 1'b0;
		end else begin
			save_r <= save_nxt;
			reload_r <= reload_nxt;
		end
	end

	assign pwm_enable_o = pwm_en_r;
	assign soft_start_o = ss_r;
	assign save_fault_id_o = save_r;
	assign reload_config_o = reload_r;
	assign state_o = state_r;

endmodule

// ### tb/frdc_stage_model.sv
`timescale 1ns/1ns
module frdc_stage_model (
	// Stage control
	input wire logic pwm_enable_i,
	// Fault injection from the bench
	input wire logic [3:0] cmd_i,
	// Fault detector levels
	output logic [3:0] fault_o
);
	// Output-side faults build up only while switching; supply faults do not care
	assign fault_o = cmd_i & {2'b11, {2{pwm_enable_i}}};
endmodule

// ### tb/frdc_top_sva.sv
`timescale 1ns/1ns
module frdc_chk (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	// Faults and status inputs
	input wire logic fast_ov_fault_i,
	input wire logic open_loop_fault_i,
	input wire logic io_ov_fault_i,
	input wire logic core_ov_fault_i,
	input wire logic flag_clear_i,
	input wire logic power_on_request_i,
	input wire logic line_ok_raw_i,
	input wire logic power_good_raw_i,
	// Block outputs
	input wire logic pwm_enable_o,
	input wire logic soft_start_o,
	input wire logic save_fault_id_o,
	input wire logic reload_config_o,
	input wire logic line_ok_output_o,
	input wire logic power_good_output_o,
	input wire logic [3:0] fault_flags_o,
	input wire logic [2:0] state_o
);
	// Shadow of written settings, so codes are known without peeking inside
	logic [7:0] sh_r [8];
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sh_r <= '{default: 8'h00};
		end else if (reg_wr_i && reg_addr_i[15:3] == 13'h1FC0) begin
			sh_r[reg_addr_i[2:0]] <= reg_wdata_i;
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	a_rsvd_zero: assert property (reg_rd_i && reg_addr_i inside {16'hFE01, 16'hFE02}
		|=> reg_rdata_o[5:0] == 6'h00) else $error("reserved bits read nonzero");
	a_unmapped_zero: assert property (reg_rd_i && !(reg_addr_i inside {[16'hFE01:16'hFE05]})
		|=> reg_rdata_o == 8'h00) else $error("unmapped read nonzero");
	a_pwm_in_run: assert property (pwm_enable_o == (state_o == 3'h2))
		else $error("pwm enable outside run");
	a_start_pulse: assert property (soft_start_o == $rose(pwm_enable_o))
		else $error("soft start not tied to pwm start");
	a_ignore_keeps: assert property (pwm_enable_o && power_on_request_i && !io_ov_fault_i
		&& !core_ov_fault_i && sh_r[1][7:6] == 2'h0 && sh_r[2][7:6] == 2'h0 |=> pwm_enable_o)
		else $error("pwm stopped on ignored fault");
	a_restart_fast: assert property (state_o == 3'h2 && power_on_request_i && fast_ov_fault_i
		&& !open_loop_fault_i && sh_r[1][7:6] == 2'h1 |=> !pwm_enable_o ##1 pwm_enable_o)
		else $error("restart action wrong");
	a_wait_latch: assert property (state_o == 3'h2 && power_on_request_i && open_loop_fault_i
		&& !fast_ov_fault_i && sh_r[2][7:6] == 2'h2 |=> state_o == 3'h5 && !pwm_enable_o)
		else $error("wait action did not stop at once");
	a_latch_holds: assert property (state_o == 3'h5 && power_on_request_i
		&& $past(power_on_request_i) |=> state_o == 3'h5) else $error("latched left early");
	a_disable_holds: assert property (state_o == 3'h4 && fault_flags_o[1:0] != 2'h0
		&& !flag_clear_i |=> !pwm_enable_o) else $error("disable resumed with flag set");
	a_save_cause: assert property (save_fault_id_o |-> sh_r[3][6] || sh_r[4][6])
		else $error("save request without enable");
	a_reload_cause: assert property (reload_config_o |-> sh_r[3][2] || sh_r[4][2])
		else $error("reload request without enable");
	a_lok_rise_zero: assert property (sh_r[5][7:6] == 2'h0 && line_ok_raw_i
		|=> line_ok_output_o) else $error("line-ok zero rise debounce delayed");
	a_pg_fall_zero: assert property (sh_r[5][1:0] == 2'h0 && !power_good_raw_i
		|=> !power_good_output_o) else $error("power-good zero fall debounce delayed");
	a_lok_held: assert property ($rose(line_ok_output_o) |-> $past(line_ok_raw_i))
		else $error("line-ok rose without raw level");
	c_latched: cover property (state_o == 3'h5);
	c_save: cover property (save_fault_id_o);
	c_lok_rise: cover property ($rose(line_ok_output_o));
endmodule
bind frdc_top frdc_chk chk_u (.*);

// ### tb/tb_fault_response_debounce_cfg.sv
`timescale 1ns/1ns
module tb_fault_response_debounce_cfg;
	localparam int DN [4] = '{1, 6, 12, 20};
	localparam logic [7:0] MSK [5] = '{8'hC0, 8'hC0, 8'h7F, 8'h7F, 8'hFF};
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic flag_clear_i = 1'b0;
	logic power_on_request_i = 1'b0;
	logic line_ok_raw_i = 1'b0;
	logic power_good_raw_i = 1'b0;
	logic [15:0] reg_addr_i = 16'h0000;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [1:0] pon_delay_sel_i = 2'h0;
	logic [3:0] cmd = 4'h0;
	wire fast_ov_fault_i, open_loop_fault_i, io_ov_fault_i, core_ov_fault_i;
	logic [7:0] reg_rdata_o;
	logic [3:0] fault_flags_o;
	logic [2:0] state_o;
	logic pwm_enable_o, soft_start_o, save_fault_id_o, reload_config_o;
	logic line_ok_output_o, power_good_output_o;
	int failures = 0;
	int comparisons = 0;
	always #10 mclk_i = ~mclk_i;
	// Millisecond counts shortened except the two longer power-on delays; supply debounce keeps its real length
	localparam int DS = int'(frdc_pkg::DEB_SHORT_CYC);
	frdc_top #(.RETRY_UNIT(20), .STAT_DEB1(6), .STAT_DEB2(12), .STAT_DEB3(20),
		.PON_DLY1(10)) dut_u (.*);
	frdc_stage_model stage_u (.pwm_enable_i(pwm_enable_o), .cmd_i(cmd),
		.fault_o({core_ov_fault_i, io_ov_fault_i, open_loop_fault_i, fast_ov_fault_i}));
	// ------
	// Helpers
	// ------
	task automatic print_verdict();
		if (failures == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic clr();
		tick(1);
		flag_clear_i = 1'b1;
		tick(1);
		flag_clear_i = 1'b0;
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		tick(1);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		tick(1);
		reg_wr_i = 1'b0;
	endtask
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		tick(1);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		tick(1);
		reg_rd_i = 1'b0;
		d = reg_rdata_o;
	endtask
	task automatic wait_pwm(input int lim, output int n);
		n = 0;
		while (pwm_enable_o !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
		if (pwm_enable_o !== 1'b1) begin
			$display("BAD pwm_enable_o expected 1 seen %b", pwm_enable_o);
			failures++;
			print_verdict();
		end
	endtask
	// ------
	// Scenarios
	// ------
	task automatic t_regs();
		logic [7:0] d;
		for (int i = 0; i < 5; i++) begin
			rd_reg(16'hFE01 + 16'(i), d);
			chk("reset value", 8'h00, d);
			wr_reg(16'hFE01 + 16'(i), 8'hFF);
			rd_reg(16'hFE01 + 16'(i), d);
			chk("register readback", MSK[i], d);
			wr_reg(16'hFE01 + 16'(i), 8'h00);
		end
		wr_reg(16'hFE00, 8'hFF);
		rd_reg(16'hFE00, d);
		chk("unmapped read", 8'h00, d);
	endtask
	task automatic t_pon();
		int n;
		pon_delay_sel_i = 2'h1;
		power_on_request_i = 1'b1;
		wait_pwm(40, n);
		chk("power-on delay", 8'h01, 8'(n >= 10 && n <= 14));
		chk("soft start", 8'h01, 8'(soft_start_o));
		power_on_request_i = 1'b0;
		tick(3);
		pon_delay_sel_i = 2'h0;
		power_on_request_i = 1'b1;
		wait_pwm(6, n);
		chk("zero power-on delay", 8'h01, 8'(n <= 3));
	endtask
	task automatic no_trip(input int s, input logic [7:0] v, input int h);
		logic lo;
		lo = 1'b0;
		wr_reg(16'hFE01 + 16'(s), v);
		cmd[s] = 1'b1;
		for (int i = 0; i < h + 4; i++) begin
			tick(1);
			if (i == h) cmd[s] = 1'b0;
			lo |= !pwm_enable_o;
		end
		chk("pwm kept", 8'h00, 8'(lo));
		chk("no flag", 8'h00, 8'(fault_flags_o));
	endtask
	task automatic t_act(input int s);
		int n;
		logic lo;
		for (int c = 1; c < 4; c++) begin
			lo = 1'b0;
			wr_reg(16'hFE01 + 16'(s), 8'(c << 6));
			cmd[s] = 1'b1;
			repeat (3) begin
				tick(1);
				lo |= !pwm_enable_o;
			end
			cmd[s] = 1'b0;
			chk("pwm stopped", 8'h01, 8'(lo));
			chk("fault flag", 8'h01, 8'(fault_flags_o[s]));
			if (c == 2) begin
				tick(8);
				chk("latched state", 8'h05, 8'(state_o));
				power_on_request_i = 1'b0;
				tick(2);
				power_on_request_i = 1'b1;
			end
			if (c == 3) begin
				tick(8);
				chk("disabled pwm", 8'h00, 8'(pwm_enable_o));
				clr();
			end
			wait_pwm(10, n);
			clr();
		end
		wr_reg(16'hFE01 + 16'(s), 8'h00);
	endtask
	task automatic trip(input int s, input logic [7:0] v, input int k);
		int f, r;
		logic sv, rl;
		f = -1;
		r = -1;
		sv = 1'b0;
		rl = 1'b0;
		wr_reg(16'hFE01 + 16'(s), v);
		cmd[s] = 1'b1;
		for (int i = 1; i <= DS + 72; i++) begin
			tick(1);
			if (i == DS + 2) cmd[s] = 1'b0;
			if (f < 0 && !pwm_enable_o) f = i;
			if (f >= 0 && r < 0 && pwm_enable_o) r = i;
			sv |= save_fault_id_o;
			rl |= reload_config_o;
		end
		chk("short debounce trip", 8'h01, 8'(f >= DS && f <= DS + 3));
		chk("retry wait", 8'h01, 8'(r - f >= 20 * k - 1 && r - f <= 20 * k + 4));
		chk("save request", 8'(v[6]), 8'(sv));
		chk("reload request", 8'(v[2]), 8'(rl));
		clr();
	endtask
	task automatic deb_edge(input logic lvl, input int nl, input int np);
		int tl, tp;
		tl = -1;
		tp = -1;
		line_ok_raw_i = lvl;
		power_good_raw_i = lvl;
		for (int i = 1; i <= 26; i++) begin
			tick(1);
			if (tl < 0 && line_ok_output_o === lvl) tl = i;
			if (tp < 0 && power_good_output_o === lvl) tp = i;
		end
		chk("line-ok debounce", 8'h01, 8'(tl >= nl - 1 && tl <= nl + 2));
		chk("power-good debounce", 8'h01, 8'(tp >= np - 1 && tp <= np + 2));
	endtask
	task automatic t_deb();
		for (int k = 0; k < 4; k++) begin
			wr_reg(16'hFE05, {2'(k), 2'(k + 1), 2'(k + 2), 2'(k + 3)});
			deb_edge(1'b1, DN[k], DN[(k + 2) % 4]);
			deb_edge(1'b0, DN[(k + 1) % 4], DN[(k + 3) % 4]);
		end
		line_ok_raw_i = 1'b1;
		tick(4);
		line_ok_raw_i = 1'b0;
		tick(6);
		chk("line-ok glitch", 8'h00, 8'(line_ok_output_o));
	endtask
	initial begin
		tick(6);
		rst_i = 1'b0;
		t_regs();
		t_pon();
		no_trip(0, 8'h00, 3);
		no_trip(1, 8'h00, 3);
		t_act(0);
		t_act(1);
		no_trip(2, 8'h03, DS + 4);
		no_trip(3, 8'h03, DS + 4);
		no_trip(2, 8'h00, DS + 4);
		trip(2, 8'h4E, 1);
		trip(3, 8'h12, 2);
		t_deb();
		print_verdict();
	end
endmodule
